//--- include/sgr_pkg.sv
// constants, field positions and types of the supply gain reduction manager
// assumes a 125 MHz pclk and comparator flags that are asynchronous to it
package sgr_pkg;
  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 125_000_000;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int TICK_S          = 1;
  localparam int TICK_CYC        = CLK_HZ * TICK_S;
  localparam int INST_PERIOD_S   = 30;
  localparam int AVG_STEP_S      = 10;
  localparam int LOWBAT_MIN      = 5;
  localparam int LOWBAT_REPEAT_S = LOWBAT_MIN * 60;
  localparam logic [4:0] INST_LAST = 5'(INST_PERIOD_S / TICK_S - 1);
  localparam logic [3:0] AVG_LAST  = 4'(AVG_STEP_S / TICK_S - 1);
  localparam logic [8:0] LB_LAST   = 9'(LOWBAT_REPEAT_S / TICK_S - 1);
  // ----------------------------------------------------------------
  // reduction steps
  // ----------------------------------------------------------------
  localparam logic [1:0] INST_MAX     = 2'h2;
  localparam logic [4:0] AVG_MAX      = 5'h12;
  localparam logic [4:0] INST_STEP_DB = 5'h03;
  // ----------------------------------------------------------------
  // synchronised input flags
  // ----------------------------------------------------------------
  localparam int NFLAG        = 10;
  localparam int F_INST_LT060 = 0;
  localparam int F_INST_LT095 = 1;
  localparam int F_INST_GT100 = 2;
  localparam int F_INST_GT110 = 3;
  localparam int F_AVG_LT095  = 4;
  localparam int F_AVG_GT110  = 5;
  localparam int F_LOWBAT     = 6;
  localparam int F_RAMP_DN    = 7;
  localparam int F_SDA        = 8;
  localparam int F_SCL        = 9;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_LBTHR  = 8'h04;
  localparam logic [7:0] ADDR_PARAM  = 8'h08;
  localparam logic [7:0] ADDR_NVM    = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int CTRL_LB_EN  = 0;
  localparam int CTRL_I2C    = 1;
  localparam int NVM_BURN    = 0;
  localparam logic [1:0]  CTRL_RST  = 2'h0;
  localparam logic [7:0]  LBTHR_RST = 8'h00;
  localparam logic [31:0] PARAM_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SHALLOW = 2'h0,
    MODE_DEEP    = 2'h1,
    MODE_ADV     = 2'h2
  } sgr_mode_t;
  typedef enum logic [2:0] {
    ST_RUN  = 3'h1,
    ST_MUTE = 3'h2,
    ST_OFF  = 3'h4
  } sgr_pwr_t;
  // total reduction in dB
  function automatic logic [4:0] sgr_gain(input logic [1:0] inst, input logic [4:0] avg);
    sgr_gain = 5'(inst * INST_STEP_DB) + avg;
  endfunction
endpackage

//--- include/sgr_sense_if.sv
// synchronised comparator flags and the one-second tick
// assumes both producers run on the same pclk as the core
interface sgr_sense_if;
  logic [sgr_pkg::NFLAG-1:0] flags;
  logic                      sec_tick;
  modport sync_mp (output flags);
  modport tick_mp (output sec_tick);
  modport core_mp (input flags, input sec_tick);
endinterface

//--- logic/sgr_sync.sv
// three-stage synchroniser with agreement filter
// assumes inputs asynchronous to pclk
module sgr_sync (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [sgr_pkg::NFLAG-1:0] raw,
  sgr_sense_if.sync_mp                   sense
);
  logic [sgr_pkg::NFLAG-1:0] s1_reg;
  logic [sgr_pkg::NFLAG-1:0] s2_reg;
  logic [sgr_pkg::NFLAG-1:0] s3_reg;
  logic [sgr_pkg::NFLAG-1:0] out_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // change taken only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) out_reg <= '0;
    else out_reg <= (s3_reg & ~(s2_reg ^ s3_reg)) | (out_reg & (s2_reg ^ s3_reg));
  end

  assign sense.flags = out_reg;
endmodule // sgr_sync

//--- logic/sgr_tick.sv
// prescaler giving one pclk pulse per second
// assumes pclk at the rate of the package clock constant
module sgr_tick #(
  parameter int TICK_CYC = sgr_pkg::TICK_CYC
) (
  input  wire logic    pclk,
  input  wire logic    presetn,
  sgr_sense_if.tick_mp sense
);
  localparam int CW = $clog2(TICK_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);
  logic [CW-1:0] cnt_reg;
  logic          tick_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (cnt_reg == LAST);
      cnt_reg  <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
    end
  end

  assign sense.sec_tick = tick_reg;
endmodule // sgr_tick

//--- logic/sgr_manager.sv
// supply gain reduction manager: reset modes, gain steps, low battery reminder
// assumes raw comparator flags from the analog block and an APB master on pclk
//
// The APB interface to the registers and the address map are this design's own decisions.

// What this block does
// [RULE1] deep mode: run above 0.95 V, mute as soon as supply drops below
// [RULE2] deep mode: stay muted until below 0.6 V, reset, reload first profile, resume above 1.1 V
// [RULE3] advanced: instantaneous dip below 0.95 V with good average adds 3 dB
// [RULE4] after an instantaneous step, dips are ignored for 30 seconds
// [RULE5] second dip adds another 3 dB and restarts hold; two steps at most
// [RULE6] instantaneous above 1.1 V for whole period removes all instantaneous steps
// [RULE7] two steps and above 1.0 V for whole period drops to one step
// [RULE8] average below 0.95 V: 1 dB per 10 s, mute after 18 steps
// [RULE9] average above 1.1 V: unmute first, then restore 1 dB per 10 s
// [RULE10] average between 0.95 V and 1.1 V: no step change
// [RULE11] instantaneous and average reduction kept in separate state
// [RULE12] advanced: instantaneous below 0.6 V forces reset; restart as shallow
// [RULE13] shallow restart resumes old profile unless supply fell below 0.6 V
// [RULE14] low battery indicator when enabled, repeated every five minutes until shutdown
// [RULE15] mute audio through fader while parameters change over the link
// [RULE16] link parameters volatile; explicit command burns them to nonvolatile memory
// [RULE17] in I2C mode data pin is bidirectional, clock pin is interface clock
// [RULE18] applied reduction is instantaneous plus average; mode input picks behaviour
// [RULE19] thresholds arrive as synchronised flags; intervals counted from a second tick
module sgr_manager #(
  parameter int TICK_CYC = sgr_pkg::TICK_CYC
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [1:0]                por_mode,
  input  wire logic [sgr_pkg::NFLAG-1:0] cmp_raw,
  input  wire logic                      prog_busy,
  input  wire logic                      prog_sda_drive,
  output logic                           sda_o,
  output logic                           sda_oe,
  output logic                           link_sda_rx,
  output logic                           link_scl_rx,
  output logic                           audio_mute,
  output logic      [1:0]                inst_steps,
  output logic      [4:0]                avg_steps,
  output logic      [4:0]                gain_red_db,
  output logic                           hw_reset_req,
  output logic                           mem_load,
  output logic                           mem_first,
  output logic                           lowbat_beep,
  output logic      [7:0]                lowbat_thr,
  output logic      [31:0]               param_out,
  output logic                           nvm_write_req
);
  // ----------------------------------------------------------------
  // sensing
  // ----------------------------------------------------------------
  sgr_sense_if sense ();
  sgr_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (cmp_raw),
    .sense   (sense.sync_mp)
  );
  sgr_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .sense   (sense.tick_mp)
  );
  logic tick;
  logic f_lt060, f_lt095, f_gt100, f_gt110;
  logic a_lt095, a_gt110, f_lowbat, f_ramp;
  assign tick     = sense.sec_tick; // see [RULE19]
  assign f_lt060  = sense.flags[sgr_pkg::F_INST_LT060];
  assign f_lt095  = sense.flags[sgr_pkg::F_INST_LT095];
  assign f_gt100  = sense.flags[sgr_pkg::F_INST_GT100];
  assign f_gt110  = sense.flags[sgr_pkg::F_INST_GT110];
  assign a_lt095  = sense.flags[sgr_pkg::F_AVG_LT095];
  assign a_gt110  = sense.flags[sgr_pkg::F_AVG_GT110];
  assign f_lowbat = sense.flags[sgr_pkg::F_LOWBAT];
  assign f_ramp   = sense.flags[sgr_pkg::F_RAMP_DN];
  logic is_deep, is_adv;
  assign is_deep = (por_mode == sgr_pkg::MODE_DEEP); // see [RULE18]
  assign is_adv  = (por_mode == sgr_pkg::MODE_ADV);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0]  ctrl_reg;
  logic [7:0]  lbthr_reg;
  logic [31:0] param_reg;
  logic        nvm_reg;
  logic [31:0] prdata_reg;
  logic        wr_en, hit;
  logic [31:0] rd_mux;
  logic [14:0] status_w;
  assign hit = (paddr == sgr_pkg::ADDR_CTRL) || (paddr == sgr_pkg::ADDR_LBTHR)
            || (paddr == sgr_pkg::ADDR_PARAM) || (paddr == sgr_pkg::ADDR_NVM)
            || (paddr == sgr_pkg::ADDR_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= sgr_pkg::CTRL_RST;
      lbthr_reg <= sgr_pkg::LBTHR_RST;
      param_reg <= sgr_pkg::PARAM_RST; // see [RULE16]
    end else if (wr_en) begin
      if (paddr == sgr_pkg::ADDR_CTRL) ctrl_reg <= pwdata[1:0];
      if (paddr == sgr_pkg::ADDR_LBTHR) lbthr_reg <= pwdata[7:0];
      if (paddr == sgr_pkg::ADDR_PARAM) param_reg <= pwdata;
    end
  end
  // burn only on explicit command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) nvm_reg <= 1'b0;
    else nvm_reg <= wr_en & (paddr == sgr_pkg::ADDR_NVM) & pwdata[sgr_pkg::NVM_BURN]; // see [RULE16]
  end
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      sgr_pkg::ADDR_CTRL:   rd_mux = {30'h0000_0000, ctrl_reg};
      sgr_pkg::ADDR_LBTHR:  rd_mux = {24'h00_0000, lbthr_reg};
      sgr_pkg::ADDR_PARAM:  rd_mux = param_reg;
      sgr_pkg::ADDR_STATUS: rd_mux = {17'h0_0000, status_w};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end
  // read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_reg <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite) prdata_reg <= rd_mux;
  end
  assign prdata = prdata_reg;
  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  sgr_pkg::sgr_pwr_t st_reg;
  logic fell_reg, load_reg, first_reg, off_cond;
  assign off_cond = (is_deep | is_adv) ? f_lt060 : f_ramp; // see [RULE12]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_reg <= sgr_pkg::ST_RUN;
    else begin
      unique case (st_reg)
        sgr_pkg::ST_RUN: begin
          if (off_cond) st_reg <= sgr_pkg::ST_OFF;
          else if (!is_adv && f_lt095) st_reg <= sgr_pkg::ST_MUTE; // see [RULE1]
        end
        sgr_pkg::ST_MUTE: begin
          if (off_cond) st_reg <= sgr_pkg::ST_OFF; // see [RULE2]
          else if (!is_deep && !is_adv && f_gt110) st_reg <= sgr_pkg::ST_RUN;
        end
        sgr_pkg::ST_OFF: begin
          if (f_gt110 && !f_lt060) st_reg <= sgr_pkg::ST_RUN; // see [RULE2]
        end
        default: st_reg <= sgr_pkg::ST_OFF;
      endcase
    end
  end
  // profile reload choice at restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fell_reg  <= 1'b0;
      load_reg  <= 1'b0;
      first_reg <= 1'b1;
    end else begin
      load_reg <= 1'b0;
      if (f_lt060) fell_reg <= 1'b1;
      if (st_reg == sgr_pkg::ST_OFF && f_gt110 && !f_lt060) begin
        load_reg  <= 1'b1;
        first_reg <= is_deep | fell_reg; // see [RULE13]
        fell_reg  <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // instantaneous reduction
  // ----------------------------------------------------------------
  logic [1:0] inst_reg;
  logic [4:0] icnt_reg;
  logic       hold_reg, ok110_reg, ok100_reg, dip, inst_clr;
  assign inst_clr = !is_adv || (st_reg == sgr_pkg::ST_OFF);
  assign dip = f_lt095 & ~a_lt095 & ~hold_reg & (inst_reg != sgr_pkg::INST_MAX); // see [RULE3]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inst_reg  <= 2'h0;
      icnt_reg  <= 5'h00;
      hold_reg  <= 1'b0;
      ok110_reg <= 1'b1;
      ok100_reg <= 1'b1;
    end else if (inst_clr) begin
      inst_reg  <= 2'h0;
      icnt_reg  <= 5'h00;
      hold_reg  <= 1'b0;
      ok110_reg <= 1'b1;
      ok100_reg <= 1'b1;
    end else if (dip) begin
      inst_reg  <= inst_reg + 2'h1; // see [RULE5]
      icnt_reg  <= 5'h00;
      hold_reg  <= 1'b1; // see [RULE4]
      ok110_reg <= 1'b1;
      ok100_reg <= 1'b1;
    end else if (tick && icnt_reg == sgr_pkg::INST_LAST) begin
      icnt_reg  <= 5'h00;
      hold_reg  <= 1'b0;
      ok110_reg <= 1'b1;
      ok100_reg <= 1'b1;
      if (ok110_reg && f_gt110) inst_reg <= 2'h0; // see [RULE6]
      else if (inst_reg == sgr_pkg::INST_MAX && ok100_reg && f_gt100) inst_reg <= 2'h1; // see [RULE7]
    end else begin
      if (tick) icnt_reg <= icnt_reg + 5'h01;
      ok110_reg <= ok110_reg & f_gt110;
      ok100_reg <= ok100_reg & f_gt100;
    end
  end
  // ----------------------------------------------------------------
  // average reduction, independent of the above
  // ----------------------------------------------------------------
  logic [4:0] avg_reg;
  logic [3:0] acnt_reg;
  logic       amute_reg, astep;
  assign astep = tick && (acnt_reg == sgr_pkg::AVG_LAST);
  always_ff @(posedge pclk or negedge presetn) begin // see [RULE11]
    if (!presetn) begin
      avg_reg   <= 5'h00;
      acnt_reg  <= 4'h0;
      amute_reg <= 1'b0;
    end else if (inst_clr) begin
      avg_reg   <= 5'h00;
      acnt_reg  <= 4'h0;
      amute_reg <= 1'b0;
    end else if (a_gt110) begin
      if (amute_reg) begin
        amute_reg <= 1'b0; // see [RULE9]
        acnt_reg  <= 4'h0;
      end else if (avg_reg != 5'h00) begin
        acnt_reg <= astep ? 4'h0 : acnt_reg + 4'(tick);
        if (astep) avg_reg <= avg_reg - 5'h01; // see [RULE9]
      end else acnt_reg <= 4'h0;
    end else if (a_lt095 && !amute_reg) begin
      acnt_reg <= astep ? 4'h0 : acnt_reg + 4'(tick);
      if (astep) begin
        avg_reg <= avg_reg + 5'h01; // see [RULE8]
        if (avg_reg + 5'h01 == sgr_pkg::AVG_MAX) amute_reg <= 1'b1;
      end
    end else acnt_reg <= 4'h0; // see [RULE10]
  end
  // ----------------------------------------------------------------
  // low battery reminder
  // ----------------------------------------------------------------
  logic [8:0] lcnt_reg;
  logic       lact_reg, beep_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcnt_reg <= 9'h000;
      lact_reg <= 1'b0;
      beep_reg <= 1'b0;
    end else begin
      beep_reg <= 1'b0;
      if (!ctrl_reg[sgr_pkg::CTRL_LB_EN] || st_reg == sgr_pkg::ST_OFF) begin
        lact_reg <= 1'b0;
        lcnt_reg <= 9'h000;
      end else if (!lact_reg) begin
        if (f_lowbat) begin
          lact_reg <= 1'b1; // see [RULE14]
          beep_reg <= 1'b1;
          lcnt_reg <= 9'h000;
        end
      end else if (tick) begin
        if (lcnt_reg == sgr_pkg::LB_LAST) begin
          beep_reg <= 1'b1; // see [RULE14]
          lcnt_reg <= 9'h000;
        end else lcnt_reg <= lcnt_reg + 9'h001;
      end
    end
  end
  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic       mute_reg;
  logic [4:0] gain_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_reg <= 1'b1;
      gain_reg <= 5'h00;
    end else begin
      mute_reg <= (st_reg != sgr_pkg::ST_RUN) | amute_reg | prog_busy; // see [RULE15]
      gain_reg <= sgr_pkg::sgr_gain(inst_reg, avg_reg); // see [RULE18]
    end
  end
  assign status_w      = {mute_reg, amute_reg, hold_reg, lact_reg, avg_reg, inst_reg, 1'b0, st_reg};
  assign audio_mute    = mute_reg;
  assign gain_red_db   = gain_reg;
  assign inst_steps    = inst_reg;
  assign avg_steps     = avg_reg;
  assign hw_reset_req  = (st_reg == sgr_pkg::ST_OFF);
  assign mem_load      = load_reg;
  assign mem_first     = first_reg;
  assign lowbat_beep   = beep_reg;
  assign lowbat_thr    = lbthr_reg;
  assign param_out     = param_reg;
  assign nvm_write_req = nvm_reg;
  assign sda_o         = 1'b0;
  assign sda_oe        = ctrl_reg[sgr_pkg::CTRL_I2C] & prog_sda_drive; // see [RULE17]
  assign link_sda_rx   = sense.flags[sgr_pkg::F_SDA]; // see [RULE17]
  assign link_scl_rx   = sense.flags[sgr_pkg::F_SCL];
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_DEEP_MUTE: assert property (is_deep && st_reg == sgr_pkg::ST_RUN && f_lt095 && !f_lt060
    |=> ##1 audio_mute) else $error("deep mode did not mute"); // see [RULE1]
  AST_DEEP_OFF: assert property (is_deep && st_reg == sgr_pkg::ST_MUTE && f_lt060
    |=> hw_reset_req) else $error("deep mode did not reset"); // see [RULE2]
  AST_DIP_STEP: assert property (dip && !inst_clr |=> inst_reg == $past(inst_reg) + 2'h1 && hold_reg)
    else $error("dip did not add a step"); // see [RULE3]
  AST_HOLD_IGNORE: assert property (hold_reg && f_lt095 |=> inst_reg <= $past(inst_reg))
    else $error("dip taken during hold"); // see [RULE4]
  AST_INST_CAP: assert property (inst_reg <= sgr_pkg::INST_MAX)
    else $error("more than two instantaneous steps"); // see [RULE5]
  AST_AVG_CAP: assert property (avg_reg <= sgr_pkg::AVG_MAX && (avg_reg == sgr_pkg::AVG_MAX || !amute_reg))
    else $error("average steps or mute out of step"); // see [RULE8]
  AST_MID_HOLD: assert property (!inst_clr && !a_lt095 && !a_gt110 |=> $stable(avg_reg))
    else $error("average step changed in dead band"); // see [RULE10]
  AST_GAIN_SUM: assert property (1'b1 |=> gain_red_db == 5'($past(inst_reg) * 3) + $past(avg_reg))
    else $error("gain is not the sum of reductions"); // see [RULE18]
  AST_FADER: assert property (prog_busy |=> audio_mute)
    else $error("fader did not mute during programming"); // see [RULE15]
  AST_LB_OFF: assert property (!ctrl_reg[sgr_pkg::CTRL_LB_EN] |=> !lowbat_beep)
    else $error("indicator while disabled"); // see [RULE14]
  COV_INST2: cover property (inst_reg == 2'h2);
  COV_AVG_MUTE: cover property (amute_reg ##1 !amute_reg);
  COV_RESTART: cover property (mem_load && !mem_first);
  COV_BEEP: cover property (lowbat_beep);
endmodule // sgr_manager

//--- dv/sgr_supply_model.sv
// supply comparators and programming host facing the manager
// assumes supply levels in mV, changed by the bench just after pclk edges
module sgr_supply_model (
  input  wire logic       sda_o,
  input  wire logic       sda_oe,
  input  int              inst_mv,
  input  int              avg_mv,
  input  wire logic       lowbat,
  output logic      [9:0] cmp_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_pin;
  // open drain with pull-up, host never pulls while idle
  assign sda_pin    = (sda_oe && !sda_o) ? 1'b0 : 1'b1;
  assign cmp_raw[0] = inst_mv < 600;
  assign cmp_raw[1] = inst_mv < 950;
  assign cmp_raw[2] = inst_mv > 1000;
  assign cmp_raw[3] = inst_mv > 1100;
  assign cmp_raw[4] = avg_mv < 950;
  assign cmp_raw[5] = avg_mv > 1100;
  assign cmp_raw[6] = lowbat;
  assign cmp_raw[7] = inst_mv < 800;
  assign cmp_raw[8] = sda_pin;
  // host clock stands high between frames
  assign cmp_raw[9] = 1'b1;
endmodule // sgr_supply_model

//--- dv/supply_gain_reduction_manager_tb.sv
// self-checking bench of the supply gain reduction manager
// assumes the supply model beside it and a shortened one-second tick
module supply_gain_reduction_manager_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic prog_busy = 0, prog_sda_drive = 0, lowbat = 0, er;
  logic [7:0]  paddr = 8'h00, lowbat_thr;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata, param_out;
  logic [1:0]  por_mode = 2'h2, inst_steps;
  logic [4:0]  avg_steps, gain_red_db;
  logic [9:0]  cmp_raw;
  logic pready, pslverr, sda_o, sda_oe, link_sda_rx, link_scl_rx, audio_mute;
  logic hw_reset_req, mem_load, mem_first, lowbat_beep, nvm_write_req;
  int   inst_mv = 1200, avg_mv = 1200, err_total = 0, comparisons = 0, cycles = 0, loads = 0;

  sgr_manager #(.TICK_CYC(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_mode(por_mode), .cmp_raw(cmp_raw), .prog_busy(prog_busy), .prog_sda_drive(prog_sda_drive),
    .sda_o(sda_o), .sda_oe(sda_oe), .link_sda_rx(link_sda_rx), .link_scl_rx(link_scl_rx),
    .audio_mute(audio_mute), .inst_steps(inst_steps), .avg_steps(avg_steps), .gain_red_db(gain_red_db),
    .hw_reset_req(hw_reset_req), .mem_load(mem_load), .mem_first(mem_first), .lowbat_beep(lowbat_beep),
    .lowbat_thr(lowbat_thr), .param_out(param_out), .nvm_write_req(nvm_write_req));
  sgr_supply_model model (.sda_o(sda_o), .sda_oe(sda_oe), .inst_mv(inst_mv), .avg_mv(avg_mv),
    .lowbat(lowbat), .cmp_raw(cmp_raw));

  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (mem_load === 1'b1) loads++;
    if (cycles == 20000) begin
      err_total++;
      finish_test;
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task cy(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task lvl(input int i, input int a);
    @(posedge pclk);
    inst_mv <= i;
    avg_mv  <= a;
  endtask
  // request held until pready is seen high, then released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    apb(0, sgr_pkg::ADDR_CTRL, 0); chk("ctrl_reset", 32'(sgr_pkg::CTRL_RST), rd);
    apb(1, sgr_pkg::ADDR_LBTHR, 32'h0000_005A); apb(0, sgr_pkg::ADDR_LBTHR, 0);
    chk("lbthr", 32'h0000_005A, rd); chk("lbthr_port", 32'h0000_005A, 32'(lowbat_thr));
    apb(1, sgr_pkg::ADDR_PARAM, 32'hA5C3_0F96); #1; chk("param", 32'hA5C3_0F96, param_out);
    apb(1, sgr_pkg::ADDR_NVM, 32'h0000_0001); #1; chk("nvm_req", 1, 32'(nvm_write_req));
    apb(0, 8'h20, 0); chk("unmapped_err", 1, 32'(er)); chk("unmapped_data", 0, rd);
    apb(1, sgr_pkg::ADDR_CTRL, 32'h0000_0002); prog_sda_drive <= 1'b1; cy(8);
    chk("sda_oe", 1, 32'(sda_oe)); chk("sda_rx_low", 0, 32'(link_sda_rx));
    chk("sda_o", 0, 32'(sda_o));
    @(posedge pclk) prog_sda_drive <= 1'b0; cy(8); chk("sda_rx_high", 1, 32'(link_sda_rx));
    chk("scl_rx", 1, 32'(link_scl_rx));
    apb(1, sgr_pkg::ADDR_CTRL, 0);
    $display("test regs done");
  endtask
  task t_inst;
    lvl(900, 1200); cy(12); chk("inst_one", 1, 32'(inst_steps));
    chk("gain_three", 3, 32'(gain_red_db));
    lvl(1050, 1200); cy(12); lvl(900, 1200); cy(12);
    chk("inst_hold", 1, 32'(inst_steps));
    lvl(1050, 1200); cy(300); lvl(900, 1200); cy(12);
    chk("inst_two", 2, 32'(inst_steps)); chk("gain_six", 6, 32'(gain_red_db));
    lvl(1050, 1200); cy(600); chk("inst_back_one", 1, 32'(inst_steps));
    lvl(1200, 1200); cy(600); chk("inst_clear", 0, 32'(inst_steps));
    chk("avg_untouched", 0, 32'(avg_steps));
    $display("test inst done");
  endtask
  task t_avg;
    lvl(1200, 900); cy(1600); chk("avg_max", 18, 32'(avg_steps));
    chk("avg_mute", 1, 32'(audio_mute)); chk("inst_untouched", 0, 32'(inst_steps));
    apb(0, sgr_pkg::ADDR_STATUS, 0); chk("status", 32'h0000_6481, rd);
    lvl(1200, 1000); cy(200); chk("avg_band", 18, 32'(avg_steps));
    chk("avg_band_mute", 1, 32'(audio_mute));
    lvl(1200, 1200); cy(12); chk("unmute_first", 0, 32'(audio_mute));
    chk("steps_kept", 18, 32'(avg_steps));
    cy(1600); chk("avg_restored", 0, 32'(avg_steps)); chk("gain_zero", 0, 32'(gain_red_db));
    $display("test avg done");
  endtask
  task t_lowbat;
    int n;
    apb(1, sgr_pkg::ADDR_CTRL, 32'h0000_0001);
    lowbat <= 1'b1;
    n = 0;
    repeat (2450) begin
      @(posedge pclk);
      #1;
      if (lowbat_beep === 1'b1) n++;
    end
    chk("beeps", 2, 32'(n));
    @(posedge pclk) lowbat <= 1'b0;
    apb(1, sgr_pkg::ADDR_CTRL, 0);
    $display("test lowbat done");
  endtask
  task t_prog;
    @(posedge pclk) prog_busy <= 1'b1; cy(4); chk("prog_mute", 1, 32'(audio_mute));
    @(posedge pclk) prog_busy <= 1'b0; cy(4); chk("prog_unmute", 0, 32'(audio_mute));
    $display("test prog done");
  endtask
  task t_restart;
    @(posedge pclk) por_mode <= 2'h1;
    lvl(900, 1200); cy(12); chk("deep_mute", 1, 32'(audio_mute));
    lvl(1200, 1200); cy(12); chk("deep_stay", 1, 32'(audio_mute));
    lvl(500, 1200); cy(12); chk("deep_off", 1, 32'(hw_reset_req));
    lvl(1200, 1200); cy(12); chk("deep_on", 0, 32'(hw_reset_req));
    chk("deep_first", 1, 32'(mem_first)); chk("deep_run", 0, 32'(audio_mute));
    @(posedge pclk) por_mode <= 2'h2;
    lvl(500, 1200); cy(12); chk("adv_off", 1, 32'(hw_reset_req));
    lvl(1200, 1200); cy(12); chk("adv_first", 1, 32'(mem_first));
    @(posedge pclk) por_mode <= 2'h0;
    lvl(750, 1200); cy(12); chk("sh_off", 1, 32'(hw_reset_req));
    lvl(1200, 1200); cy(12); chk("sh_resume", 0, 32'(mem_first));
    chk("restart_loads", 3, 32'(loads));
    $display("test restart done");
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cy(2);
    t_regs;
    t_inst;
    t_avg;
    t_lowbat;
    t_prog;
    t_restart;
    finish_test;
  end
endmodule // supply_gain_reduction_manager_tb
